/* File: hw/sfc_consts.vh */
// Constants for the shared dual-clock FIFO block.
// Included by the top design file, the checker and the test bench; holds definitions and nothing else.
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH

// Widths and limits
`define SFC_DATA_W 32
`define SFC_FIFO_AW 5
`define SFC_MAX_DATA_W 32
`define SFC_MAX_ADDR_W 24
`define SFC_REG_AW 8

// Register offsets
`define SFC_OFF_CTRL 8'h00
`define SFC_OFF_STATUS 8'h04
`define SFC_OFF_ERR 8'h08
`define SFC_OFF_WRCOUNT 8'h0C
`define SFC_OFF_RDCOUNT 8'h10
`define SFC_OFF_PARAMS 8'h14

// Sharing modes, control field
`define SFC_MODE_PAIR 2'h0
`define SFC_MODE_WRHALF 2'h1
`define SFC_MODE_RDHALF 2'h2
`define SFC_MODE_BAD 2'h3
`define SFC_CTRL_MODE_LSB 0
`define SFC_CTRL_MODE_MSB 1
`define SFC_CTRL_RESET 2'h0

// Status fields
`define SFC_ST_EMPTY 0
`define SFC_ST_FULL 1
`define SFC_ST_MODE_LSB 2
`define SFC_ST_MODE_MSB 3

// Dropped-access flags
`define SFC_ERR_WRDROP 0
`define SFC_ERR_RDDROP 1
`define SFC_ERR_RESET 2'h0

`endif

/* File: hw/sfc_async_fifo.v */
// Dual-clock FIFO in a registered-read memory array, gray-coded pointer crossing.
// Assumes each reset is synchronous to its own clock; holds two to the power AW words in memory plus one in the output stage.
`timescale 1ns/1ps
module sfc_async_fifo #(
    parameter DW = 32,
    parameter AW = 5
) (
    input wire wrClk,
    input wire wrRst,
    input wire wrValid,
    input wire [DW-1:0] wrData,
    output wire wrReady,
    output wire [AW:0] wrCount,
    input wire rdClk,
    input wire rdRst,
    output wire rdValid,
    output wire [DW-1:0] rdData,
    input wire rdReady,
    output wire [AW:0] rdCount
);
    localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
    localparam [AW:0] ONE = {{AW{1'b0}}, 1'b1};

    function [AW:0] grayToBin;
        input [AW:0] g;
        integer i;
        begin
            grayToBin[AW] = g[AW];
            for (i = AW - 1; i >= 0; i = i - 1) begin
                grayToBin[i] = grayToBin[i + 1] ^ g[i];
            end
        end
    endfunction

    // Block memory, registered read only
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Write domain
    reg [AW:0] wrBin_q;
    reg [AW:0] wrGray_q;
    reg [AW:0] rdGrayS1_q;
    reg [AW:0] rdGrayS2_q;
    reg [AW:0] rdGray_q;
    wire [AW:0] rdBinW = grayToBin(rdGrayS2_q);
    wire [AW:0] wrUsed = wrBin_q - rdBinW;
    wire wrFire = wrValid && wrReady;
    wire [AW:0] wrBin_d = wrBin_q + ONE;

    assign wrReady = (wrUsed != DEPTH);
    assign wrCount = wrUsed;

    always @(posedge wrClk) begin
        if (wrFire) begin
            mem[wrBin_q[AW-1:0]] <= wrData;
        end
    end

    always @(posedge wrClk) begin
        if (wrRst) begin
            wrBin_q <= {(AW+1){1'b0}};
            wrGray_q <= {(AW+1){1'b0}};
            rdGrayS1_q <= {(AW+1){1'b0}};
            rdGrayS2_q <= {(AW+1){1'b0}};
        end else begin
            rdGrayS1_q <= rdGray_q;
            rdGrayS2_q <= rdGrayS1_q;
            if (wrFire) begin
                wrBin_q <= wrBin_d;
                wrGray_q <= wrBin_d ^ (wrBin_d >> 1);
            end
        end
    end

    // Read domain with one output stage
    reg [AW:0] rdBin_q;
    reg [AW:0] wrGrayS1_q;
    reg [AW:0] wrGrayS2_q;
    reg outValid_q;
    reg [DW-1:0] outData_q;
    wire [AW:0] wrBinR = grayToBin(wrGrayS2_q);
    wire memHas = (wrBinR != rdBin_q);
    wire load = memHas && (!outValid_q || rdReady);
    wire [AW:0] rdBin_d = rdBin_q + ONE;

    assign rdValid = outValid_q;
    assign rdData = outData_q;
    assign rdCount = wrBinR - rdBin_q;

    always @(posedge rdClk) begin
        if (load) begin
            outData_q <= mem[rdBin_q[AW-1:0]];
        end
    end

    always @(posedge rdClk) begin
        if (rdRst) begin
            rdBin_q <= {(AW+1){1'b0}};
            rdGray_q <= {(AW+1){1'b0}};
            wrGrayS1_q <= {(AW+1){1'b0}};
            wrGrayS2_q <= {(AW+1){1'b0}};
            outValid_q <= 1'b0;
        end else begin
            wrGrayS1_q <= wrGray_q;
            wrGrayS2_q <= wrGrayS1_q;
            if (load) begin
                rdBin_q <= rdBin_d;
                rdGray_q <= rdBin_d ^ (rdBin_d >> 1);
                outValid_q <= 1'b1;
            end else if (rdReady) begin
                outValid_q <= 1'b0;
            end
        end
    end
endmodule // sfc_async_fifo

/* File: hw/sfc_link_sync.v */
// Two-stage synchroniser for the host link pins and rising-edge finder for its clock.
// Assumes the host holds request and data steady around its rising link clock edge.
`timescale 1ns/1ps
module sfc_link_sync #(
    parameter DW = 32
) (
    input wire clk_sys,
    input wire rst,
    input wire linkClk,
    input wire linkWrReq,
    input wire linkRdReq,
    input wire [DW-1:0] linkWrData,
    output wire linkRise,
    output wire wrReq,
    output wire rdReq,
    output wire [DW-1:0] wrData
);
    localparam SW = DW + 3;

    reg [SW-1:0] s1_q;
    reg [SW-1:0] s2_q;
    reg clkPrev_q;

    // Only the second stage reads the first
    always @(posedge clk_sys) begin
        if (rst) begin
            s1_q <= {SW{1'b0}};
            s2_q <= {SW{1'b0}};
            clkPrev_q <= 1'b0;
        end else begin
            s1_q <= {linkWrData, linkRdReq, linkWrReq, linkClk};
            s2_q <= s1_q;
            clkPrev_q <= s2_q[0];
        end
    end

    assign linkRise = s2_q[0] && !clkPrev_q;
    assign wrReq = s2_q[1];
    assign rdReq = s2_q[2];
    assign wrData = s2_q[SW-1:3];
endmodule // sfc_link_sync

/* File: hw/sfc_shared_fifo.v */
// Shared FIFO top: user stream ports, host link half, plain register port.
// Assumes one system clock; host link pins come from another clock domain.
// Functional notes
// - The buffer is a FIFO with separate write and read clock ports, safe across domains.
// - Storage sits in a registered-read block memory array only.
// - In pair mode one clock drives both the write and the read clock port.
// - In pair mode both sides belong to user logic and the host has no control.
// - In write-half mode user logic writes and the host link drains words.
// - In read-half mode the host link writes and user logic consumes words.
// - Words written by the host enter the buffer in the order written and leave unchanged.
// - Empty, full and both counts seen by the host never claim more room or data than exist.
// - The data port is no wider than 32 bits.
// - The buffer address is no wider than 24 bits.
`timescale 1ns/1ps
`include "sfc_consts.vh"
module sfc_shared_fifo #(
    parameter DW = `SFC_DATA_W,
    parameter AW = `SFC_FIFO_AW
) (
    input wire clk_sys,
    input wire rst,
    input wire [`SFC_REG_AW-1:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWr,
    input wire regRd,
    output wire [31:0] regRdData,
    input wire usrWrValid,
    input wire [DW-1:0] usrWrData,
    output wire usrWrReady,
    output wire usrRdValid,
    output wire [DW-1:0] usrRdData,
    input wire usrRdReady,
    input wire linkClk,
    input wire linkWrReq,
    input wire [DW-1:0] linkWrData,
    input wire linkRdReq,
    output wire [DW-1:0] linkRdData,
    output wire linkEmpty,
    output wire linkFull
);
    // Control and status registers
    reg [1:0] mode_q;
    reg [1:0] err_q;
    reg [31:0] rdData_q;
    reg [DW-1:0] linkRdData_q;
    reg linkEmpty_q;
    reg linkFull_q;

    // Link side after synchronising
    wire linkRise;
    wire linkWrReqS;
    wire linkRdReqS;
    wire [DW-1:0] linkWrDataS;

    // FIFO ports
    reg fifoWrValid;
    reg [DW-1:0] fifoWrData;
    reg fifoRdReady;
    wire fifoWrReady;
    wire fifoRdValid;
    wire [DW-1:0] fifoRdData;
    wire [AW:0] wrCount;
    wire [AW:0] rdCount;

    // Mode decode
    wire isWrHalf = (mode_q == `SFC_MODE_WRHALF);
    wire isRdHalf = (mode_q == `SFC_MODE_RDHALF);
    wire hostWrites = isRdHalf;
    wire hostReads = isWrHalf;

    // Host link events, one per rising link clock edge
    wire linkPush = linkRise && linkWrReqS && hostWrites;
    wire linkPop = linkRise && linkRdReqS && hostReads;
    wire linkPushDrop = linkPush && !fifoWrReady;
    wire linkPopDrop = linkPop && !fifoRdValid;

    sfc_link_sync #(
        .DW(DW)
    ) uLinkSync (
        .clk_sys(clk_sys),
        .rst(rst),
        .linkClk(linkClk),
        .linkWrReq(linkWrReq),
        .linkRdReq(linkRdReq),
        .linkWrData(linkWrData),
        .linkRise(linkRise),
        .wrReq(linkWrReqS),
        .rdReq(linkRdReqS),
        .wrData(linkWrDataS)
    );

    // Write side source selection
    always @* begin
        fifoWrValid = 1'b0;
        fifoWrData = usrWrData;
        if (hostWrites) begin
            fifoWrValid = linkPush;
            fifoWrData = linkWrDataS;
        end else begin
            fifoWrValid = usrWrValid;
        end
    end

    // Read side sink selection
    always @* begin
        fifoRdReady = 1'b0;
        if (hostReads) begin
            fifoRdReady = linkPop;
        end else begin
            fifoRdReady = usrRdReady;
        end
    end

    // User handshakes gated by mode, read data is not; host has no say in pair mode
    assign usrWrReady = fifoWrReady && !hostWrites;
    assign usrRdValid = fifoRdValid && !hostReads;
    assign usrRdData = fifoRdData;

    // Same clock on both FIFO clock ports
    sfc_async_fifo #(
        .DW(DW),
        .AW(AW)
    ) uFifo (
        .wrClk(clk_sys),
        .wrRst(rst),
        .wrValid(fifoWrValid),
        .wrData(fifoWrData),
        .wrReady(fifoWrReady),
        .wrCount(wrCount),
        .rdClk(clk_sys),
        .rdRst(rst),
        .rdValid(fifoRdValid),
        .rdData(fifoRdData),
        .rdReady(fifoRdReady),
        .rdCount(rdCount)
    );

    // Host link outputs: read data, empty and full flags
    always @(posedge clk_sys) begin
        if (rst) begin
            linkRdData_q <= {DW{1'b0}};
            linkEmpty_q <= 1'b1;
            linkFull_q <= 1'b0;
        end else begin
            if (linkPop && fifoRdValid) begin
                linkRdData_q <= fifoRdData;
            end
            linkEmpty_q <= !fifoRdValid || linkPop;
            linkFull_q <= !fifoWrReady || linkPush;
        end
    end

    assign linkRdData = linkRdData_q;
    assign linkEmpty = linkEmpty_q;
    assign linkFull = linkFull_q;

    // Register writes; a new drop wins over a clear
    always @(posedge clk_sys) begin
        if (rst) begin
            mode_q <= `SFC_CTRL_RESET;
            err_q <= `SFC_ERR_RESET;
        end else begin
            if (regWr && regAddr == `SFC_OFF_CTRL &&
                regWrData[`SFC_CTRL_MODE_MSB:`SFC_CTRL_MODE_LSB] != `SFC_MODE_BAD) begin
                mode_q <= regWrData[`SFC_CTRL_MODE_MSB:`SFC_CTRL_MODE_LSB];
            end
            err_q[`SFC_ERR_WRDROP] <= linkPushDrop || (err_q[`SFC_ERR_WRDROP] &&
                !(regWr && regAddr == `SFC_OFF_ERR && regWrData[`SFC_ERR_WRDROP]));
            err_q[`SFC_ERR_RDDROP] <= linkPopDrop || (err_q[`SFC_ERR_RDDROP] &&
                !(regWr && regAddr == `SFC_OFF_ERR && regWrData[`SFC_ERR_RDDROP]));
        end
    end

    // Register reads, data in the following cycle only
    reg [31:0] rdSel;
    always @* begin
        rdSel = 32'h00000000;
        case (regAddr)
            `SFC_OFF_CTRL: begin
                rdSel[`SFC_CTRL_MODE_MSB:`SFC_CTRL_MODE_LSB] = mode_q;
            end
            `SFC_OFF_STATUS: begin
                rdSel[`SFC_ST_EMPTY] = !fifoRdValid;
                rdSel[`SFC_ST_FULL] = !fifoWrReady;
                rdSel[`SFC_ST_MODE_MSB:`SFC_ST_MODE_LSB] = mode_q;
            end
            `SFC_OFF_ERR: begin
                rdSel[1:0] = err_q;
            end
            `SFC_OFF_WRCOUNT: begin
                rdSel[AW:0] = wrCount;
            end
            `SFC_OFF_RDCOUNT: begin
                rdSel[AW:0] = rdCount;
            end
            `SFC_OFF_PARAMS: begin
                rdSel[7:0] = DW[7:0];
                rdSel[15:8] = AW[7:0];
            end
            default: begin
                rdSel = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            rdData_q <= 32'h00000000;
        end else if (regRd) begin
            rdData_q <= rdSel;
        end else begin
            rdData_q <= 32'h00000000;
        end
    end

    assign regRdData = rdData_q;
endmodule // sfc_shared_fifo

/* File: tb/sfc_shared_fifo_checker.sv */
// Checker for the shared FIFO top, bound to every instance.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "sfc_consts.vh"
module sfc_shared_fifo_checker #(
    parameter DW = 32,
    parameter AW = 5
) (
    input wire clk_sys,
    input wire rst,
    input wire [`SFC_REG_AW-1:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWr,
    input wire regRd,
    input wire [31:0] regRdData,
    input wire usrWrReady,
    input wire usrRdValid,
    input wire [DW-1:0] usrRdData,
    input wire usrRdReady,
    input wire [DW-1:0] linkRdData,
    input wire linkEmpty,
    input wire linkFull
);
    reg [1:0] modeQ;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Mode shadow
    always @(posedge clk_sys) begin
        if (rst) begin
            modeQ <= `SFC_MODE_PAIR;
        end else if (regWr && regAddr == `SFC_OFF_CTRL && regWrData[1:0] != `SFC_MODE_BAD) begin
            modeQ <= regWrData[1:0];
        end
    end
    a_reset_state: assert property (disable iff (1'b0)
        $fell(rst) |-> linkEmpty && !linkFull && !usrRdValid) else $error("bad reset state");
    a_status_empty: assert property (
        regRd && regAddr == `SFC_OFF_STATUS && modeQ == `SFC_MODE_PAIR
        |=> regRdData[0] == !$past(usrRdValid)) else $error("empty flag wrong");
    a_status_full: assert property (
        regRd && regAddr == `SFC_OFF_STATUS && modeQ != `SFC_MODE_RDHALF
        |=> regRdData[1] == !$past(usrWrReady)) else $error("full flag wrong");
    a_status_mode: assert property (
        regRd && regAddr == `SFC_OFF_STATUS |=> regRdData[3:2] == $past(modeQ))
        else $error("mode field wrong");
    a_data_width: assert property (
        regRd && regAddr == `SFC_OFF_PARAMS |=> regRdData[7:0] == DW && DW <= 32)
        else $error("data width wrong");
    a_addr_width: assert property (
        regRd && regAddr == `SFC_OFF_PARAMS |=> regRdData[15:8] == AW && AW <= 24)
        else $error("address width wrong");
    a_word_held: assert property (
        usrRdValid && !usrRdReady |=> usrRdValid && $stable(usrRdData))
        else $error("word not held");
    a_wrhalf_no_read: assert property (modeQ == `SFC_MODE_WRHALF |-> !usrRdValid)
        else $error("user read in write half");
    a_rdhalf_no_write: assert property (modeQ == `SFC_MODE_RDHALF |-> !usrWrReady)
        else $error("user write in read half");
    a_host_no_pop: assert property (modeQ != `SFC_MODE_WRHALF |=> $stable(linkRdData))
        else $error("host popped outside write half");
    c_user_full: cover property (!usrWrReady && modeQ == `SFC_MODE_PAIR);
    c_user_pop: cover property (usrRdValid && usrRdReady);
    c_host_pop: cover property (!$stable(linkRdData));
    c_host_full: cover property (linkFull);
endmodule // sfc_shared_fifo_checker

bind sfc_shared_fifo sfc_shared_fifo_checker #(.DW(DW), .AW(AW)) u_sfc_shared_fifo_checker (
    .clk_sys, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .usrWrReady,
    .usrRdValid, .usrRdData, .usrRdReady, .linkRdData, .linkEmpty, .linkFull);

/* File: tb/sfc_host_model.sv */
// Host link half: one push and/or pop per link clock period.
// Assumes the block samples the link pins with its own clock.
`timescale 1ns/1ps
module sfc_host_model #(
    parameter DW = 32
) (
    input wire clk_sys,
    output logic linkClk,
    output logic linkWrReq,
    output logic linkRdReq,
    output logic [DW-1:0] linkWrData
);
    // One host half only
    initial begin
        linkClk = 1'b0;
        linkWrReq = 1'b0;
        linkRdReq = 1'b0;
        linkWrData = '0;
    end
    // Link clock runs only within a transfer, off phase
    task xfer(input logic wr, input logic rd, input logic [DW-1:0] d);
        @(posedge clk_sys);
        linkWrReq <= wr;
        linkRdReq <= rd;
        linkWrData <= d;
        repeat (3) @(posedge clk_sys);
        #7 linkClk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #7 linkClk <= 1'b0;
        linkWrReq <= 1'b0;
        linkRdReq <= 1'b0;
        linkWrData <= ~d;
    endtask
endmodule // sfc_host_model

/* File: tb/sfc_shared_fifo_test.sv */
// Self-checking bench for the shared FIFO top.
// Assumes the host model drives the link pins; the bench drives the rest.
`timescale 1ns/1ps
`include "sfc_consts.vh"
module sfc_shared_fifo_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData;
    logic usrWrValid = 1'b0;
    logic [31:0] usrWrData = 32'h0;
    logic usrWrReady;
    logic usrRdValid;
    logic [31:0] usrRdData;
    logic usrRdReady = 1'b0;
    logic linkClk;
    logic linkWrReq;
    logic [31:0] linkWrData;
    logic linkRdReq;
    logic [31:0] linkRdData;
    logic linkEmpty;
    logic linkFull;
    int num_errors = 0;
    int cmp_count = 0;
    sfc_shared_fifo u_sfc_shared_fifo (.clk_sys, .rst, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .usrWrValid, .usrWrData, .usrWrReady, .usrRdValid, .usrRdData, .usrRdReady,
        .linkClk, .linkWrReq, .linkWrData, .linkRdReq, .linkRdData, .linkEmpty, .linkFull);
    sfc_host_model u_sfc_host_model (.clk_sys, .linkClk, .linkWrReq, .linkRdReq, .linkWrData);
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task regW(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task regR(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(posedge clk_sys);
        chk(regRdData, exp);
    endtask
    task usrPush(input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        usrWrValid <= 1'b1;
        usrWrData <= d;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (usrWrReady !== 1'b1 && n < 20);
        usrWrValid <= 1'b0;
        usrWrData <= ~d;
        chk(n < 20, 32'h1);
    endtask
    task usrPop(input logic [31:0] exp);
        int n;
        @(posedge clk_sys);
        usrRdReady <= 1'b1;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (usrRdValid !== 1'b1 && n < 20);
        usrRdReady <= 1'b0;
        chk(usrRdData, exp);
    endtask
    task testReset();
        chk({linkFull, linkEmpty}, 32'h1);
        regR(`SFC_OFF_STATUS, 32'h1);
        regR(`SFC_OFF_PARAMS, 32'h0520);
        regR(8'h40, 32'h0);
        regW(`SFC_OFF_CTRL, 32'h3);
        regR(`SFC_OFF_CTRL, 32'h0);
    endtask
    task testPair();
        for (int i = 0; i < 33; i++) usrPush(32'hA000_0000 + i);
        @(posedge clk_sys);
        chk(usrWrReady, 32'h0);
        regR(`SFC_OFF_STATUS, 32'h2);
        regR(`SFC_OFF_WRCOUNT, 32'h20);
        regR(`SFC_OFF_RDCOUNT, 32'h20);
        usrWrValid <= 1'b1;
        usrWrData <= 32'hDEAD_0000;
        repeat (3) @(posedge clk_sys);
        usrWrValid <= 1'b0;
        for (int i = 0; i < 33; i++) begin
            repeat (i % 3) @(posedge clk_sys);
            usrPop(32'hA000_0000 + i);
        end
        repeat (8) @(posedge clk_sys);
        chk(usrRdValid, 32'h0);
        regR(`SFC_OFF_STATUS, 32'h1);
        regR(`SFC_OFF_WRCOUNT, 32'h0);
        regR(`SFC_OFF_RDCOUNT, 32'h0);
    endtask
    task testWrHalf();
        regW(`SFC_OFF_CTRL, 32'h1);
        usrPush(32'hB000_0001);
        usrPush(32'hB000_0002);
        repeat (10) @(posedge clk_sys);
        chk({linkEmpty, usrRdValid}, 32'h0);
        for (int i = 1; i < 3; i++) begin
            u_sfc_host_model.xfer(1'b0, 1'b1, 32'h0);
            chk(linkRdData, 32'hB000_0000 + i);
        end
        chk(linkEmpty, 32'h1);
        u_sfc_host_model.xfer(1'b0, 1'b1, 32'h0);
        chk(linkRdData, 32'hB000_0002);
        regR(`SFC_OFF_ERR, 32'h2);
        regW(`SFC_OFF_ERR, 32'h3);
        regR(`SFC_OFF_ERR, 32'h0);
    endtask
    task testRdHalf();
        int n;
        regW(`SFC_OFF_CTRL, 32'h2);
        @(posedge clk_sys);
        chk(usrWrReady, 32'h0);
        n = 0;
        while (linkFull !== 1'b1 && n < 40) begin
            u_sfc_host_model.xfer(1'b1, 1'b0, 32'hC000_0000 + n);
            n++;
        end
        chk(n, 32'h21);
        regR(`SFC_OFF_ERR, 32'h0);
        u_sfc_host_model.xfer(1'b1, 1'b0, 32'hDEAD_0001);
        regR(`SFC_OFF_ERR, 32'h1);
        for (int i = 0; i < n; i++) usrPop(32'hC000_0000 + i);
        repeat (8) @(posedge clk_sys);
        chk(usrRdValid, 32'h0);
        regW(`SFC_OFF_CTRL, 32'h0);
    endtask
    task wrap_up();
        $display("Checks %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        testReset();
        testPair();
        testWrHalf();
        testRdHalf();
        wrap_up();
    end
endmodule // sfc_shared_fifo_test
